// File: rtl/csp_clock_ctrl.sv
// file: clock source, trim registers, start-up delay and module power gating
`timescale 1ns/10ps

// Contract
// - factory fast trim copied into fast trim register during reset
// - firmware may rewrite fast trim any time; drives oscillator trim
// - factory slow trim copied into slow trim register during reset
// - two temperature trim registers for the fast oscillator
// - fast oscillator keeps clocking watchdog and reset time-out
// - start-up delay picked by non-volatile start-up select bit
// - unprogrammed default: fast oscillator, longest start-up, divide by eight
// - timer power-off bit halts first timer, clearing resumes it
// - bit 3 halts second timer, clearing resumes with state kept
// - bit 2 stops serial peripheral clock; software reinitialises after
// - bit 1 halts serial transceiver, clearing resumes with state kept
// - bit 0 shuts converter; comparator unavailable; software disables first
// - prescaler ratio changes never upset operation; a lowered ratio can give one short tick interval here
module csp_clock_ctrl import csp_pkg::*; #(
	parameter int                STARTUP_SHORT = STARTUP_CYC_S,
	parameter int                STARTUP_LONG  = STARTUP_CYC_L,
	parameter logic [CNT_W-1:0]  WDOG_DIV      = 12'hFFF
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// factory trim and non-volatile configuration
	input  wire logic [7:0]       factory_fast_trim,
	input  wire logic [7:0]       factory_slow_trim,
	input  wire csp_nvcfg_t       nvcfg,
	// ahb-lite slave
	input  wire logic             hsel,
	input  wire logic [7:0]       haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic [31:0]           hrdata,
	output logic                  hreadyout,
	output logic                  hresp,
	// oscillator controls
	output logic [7:0]            fast_osc_trim,
	output logic [7:0]            slow_osc_trim,
	output logic [7:0]            fast_osc_temp_trim_a,
	output logic [7:0]            fast_osc_temp_trim_b,
	output logic                  fast_osc_en,
	output logic                  slow_osc_en,
	// clock enables
	output logic                  sys_clk_en,
	output logic                  wdog_clk_en,
	output logic                  core_reset_n,
	output csp_gate_t             gate_en
);

	// ****************************************
	// reset synchroniser
	// ****************************************
	logic rst_meta;
	logic rst_n;

	// asserts at once, releases after two edges so no flop sees a runt reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ****************************************
	// bus slave
	// ****************************************
	logic        wr_pend;
	logic        next_wr_pend;
	logic [7:0]  wr_addr;
	logic [7:0]  next_wr_addr;
	logic        rd_go;
	logic        accept;
	logic [31:0] next_hrdata;

	// zero wait states: decode now, write data taken in the data phase
	assign accept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign rd_go  = accept && !hwrite;

	always_comb begin
		next_wr_pend = accept && hwrite;
		next_wr_addr = accept ? haddr : wr_addr;
	end

	// ****************************************
	// state and registers
	// ****************************************
	csp_state_t       state;
	csp_state_t       next_state;
	logic [CNT_W-1:0] su_cnt;
	logic [CNT_W-1:0] next_su_cnt;
	logic [CNT_W-1:0] su_len;
	logic             trim_loaded;
	logic             next_trim_loaded;
	logic [7:0]       next_fast_trim;
	logic [7:0]       next_slow_trim;
	logic [7:0]       next_temp_a;
	logic [7:0]       next_temp_b;
	logic [3:0]       prescale;
	logic [3:0]       next_prescale;
	logic [4:0]       pwr_off;
	logic [4:0]       next_pwr_off;
	logic [1:0]       src_sel;
	logic [1:0]       next_src_sel;
	logic [CNT_W-1:0] wd_cnt;
	logic [CNT_W-1:0] next_wd_cnt;
	logic             next_wd_en;
	logic             running;
	logic             ps_tick;
	csp_gate_t        next_gate;

	assign su_len  = nvcfg.startup_time_select ? CNT_W'(STARTUP_LONG) : CNT_W'(STARTUP_SHORT);
	assign running = (state == ST_RUN);

	// ****************************************
	// boot sequence and register writes
	// ****************************************
	// writes land only in run, so start-up traffic cannot undo the factory trims
	always_comb begin
		next_state       = state;
		next_su_cnt      = su_cnt;
		next_trim_loaded = trim_loaded;
		next_fast_trim   = fast_osc_trim;
		next_slow_trim   = slow_osc_trim;
		next_temp_a      = fast_osc_temp_trim_a;
		next_temp_b      = fast_osc_temp_trim_b;
		next_prescale    = prescale;
		next_pwr_off     = pwr_off;
		next_src_sel     = src_sel;
		case (state)
			ST_RESET: begin
				next_fast_trim   = factory_fast_trim;
				next_slow_trim   = factory_slow_trim;
				next_trim_loaded = 1'b1;
				next_src_sel     = nvcfg.clock_source_select;
				next_prescale    = nvcfg.default_divide_by_eight ? PRESCALE_DIV8 : PRESCALE_DIV1;
				next_su_cnt      = '0;
				next_state       = ST_STARTUP;
			end
			ST_STARTUP: begin
				// ends one short: the state change itself costs a cycle
				// start-up wait
				if (su_cnt >= su_len - 1'b1) begin
					next_state = ST_RUN;
				end else begin
					next_su_cnt = su_cnt + 1'b1;
				end
			end
			ST_RUN: begin
				if (wr_pend) begin
					case (wr_addr)
						OFS_FAST_TRIM: next_fast_trim = hwdata[7:0];
						OFS_SLOW_TRIM: next_slow_trim = hwdata[7:0];
						OFS_TEMP_TRIM_A: next_temp_a = hwdata[7:0];
						OFS_TEMP_TRIM_B: next_temp_b = hwdata[7:0];
						OFS_PRESCALE: begin
							if (hwdata[3:0] <= PRESCALE_MAX) begin
								next_prescale = hwdata[3:0];
							end
						end
						OFS_POWER_RED: next_pwr_off = hwdata[PR_WIDTH-1:0];
						default: begin
						end
					endcase
				end
			end
			default: next_state = ST_RESET;
		endcase
	end

	// ****************************************
	// read mux
	// ****************************************
	// registered, so read data stands in the data phase only; upper bits read zero
	always_comb begin
		next_hrdata = '0;
		if (rd_go) begin
			case (haddr)
				OFS_FAST_TRIM:   next_hrdata[7:0] = fast_osc_trim;
				OFS_SLOW_TRIM:   next_hrdata[7:0] = slow_osc_trim;
				OFS_TEMP_TRIM_A: next_hrdata[7:0] = fast_osc_temp_trim_a;
				OFS_TEMP_TRIM_B: next_hrdata[7:0] = fast_osc_temp_trim_b;
				OFS_PRESCALE:    next_hrdata[3:0] = prescale;
				OFS_POWER_RED:   next_hrdata[PR_WIDTH-1:0] = pwr_off;
				OFS_STATUS:      next_hrdata[3:0] = {trim_loaded, running, src_sel};
				OFS_CONFIG:      next_hrdata[3:0] = nvcfg;
				default:         next_hrdata = '0;
			endcase
		end
	end

	// ****************************************
	// clock gating and watchdog tick
	// ****************************************
	always_comb begin
		// pulses are masked, not clocks stopped, so gated modules keep their state
		// first timer gate
		next_gate.timer_a       = ps_tick && !pwr_off[PR_TIMER_A];
		next_gate.timer_b       = ps_tick && !pwr_off[PR_TIMER_B];
		next_gate.serial_periph = ps_tick && !pwr_off[PR_SERIAL];
		next_gate.serial_xcvr   = ps_tick && !pwr_off[PR_XCVR];
		// comparator shares the converter bit
		// converter and comparator off
		next_gate.converter     = ps_tick && !pwr_off[PR_CONVERTER];
		next_gate.comparator    = ps_tick && !pwr_off[PR_CONVERTER];
		// watchdog from fast oscillator, independent of prescaler
		next_wd_cnt = (wd_cnt >= WDOG_DIV) ? '0 : wd_cnt + 1'b1;
		next_wd_en  = (wd_cnt >= WDOG_DIV);
	end

	// ****************************************
	// system clock prescaler
	// ****************************************
	// ratio follows the prescale register directly, so a step takes effect at once
	// reset time-out also counts on the undivided fast clock
	csp_prescaler #(
		.DIV_W (8)
	) u_prescaler (
		.clk   (clk),
		.rst_n (rst_n),
		.run   (running),
		.shift (prescale),
		.tick  (ps_tick)
	);

	// ****************************************
	// registers
	// ****************************************
	// no register needs a wait state or an error, so the response is constant
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// trims read zero until the load just after reset
			state                <= ST_RESET;
			su_cnt               <= '0;
			trim_loaded          <= 1'b0;
			fast_osc_trim        <= '0;
			slow_osc_trim        <= '0;
			fast_osc_temp_trim_a <= TEMP_TRIM_RESET;
			fast_osc_temp_trim_b <= TEMP_TRIM_RESET;
			prescale             <= PRESCALE_DIV8;
			pwr_off              <= PR_RESET;
			src_sel              <= SRC_FAST_RC;
			wr_pend              <= 1'b0;
			wr_addr              <= '0;
			hrdata               <= '0;
			hreadyout            <= 1'b1;
			hresp                <= 1'b0;
			wd_cnt               <= '0;
			wdog_clk_en          <= 1'b0;
			sys_clk_en           <= 1'b0;
			core_reset_n         <= 1'b0;
			fast_osc_en          <= 1'b1;
			slow_osc_en          <= 1'b0;
			gate_en              <= '0;
		end else begin
			// boot and run state
			state                <= next_state;
			su_cnt               <= next_su_cnt;
			trim_loaded          <= next_trim_loaded;
			fast_osc_trim        <= next_fast_trim;
			slow_osc_trim        <= next_slow_trim;
			fast_osc_temp_trim_a <= next_temp_a;
			fast_osc_temp_trim_b <= next_temp_b;
			prescale             <= next_prescale;
			pwr_off              <= next_pwr_off;
			src_sel              <= next_src_sel;
			// bus side
			wr_pend              <= next_wr_pend;
			wr_addr              <= next_wr_addr;
			hrdata               <= next_hrdata;
			hreadyout            <= 1'b1;
			hresp                <= 1'b0;
			// enables and gates
			wd_cnt               <= next_wd_cnt;
			wdog_clk_en          <= next_wd_en;
			sys_clk_en           <= ps_tick;
			core_reset_n         <= running;
			// fast oscillator stays on: watchdog and time-out need it
			fast_osc_en          <= 1'b1;
			slow_osc_en          <= (next_src_sel == SRC_SLOW_RC);
			gate_en              <= next_gate;
		end
	end

endmodule // csp_clock_ctrl

// File: rtl/csp_pkg.sv
// package: register map, fields, reset values and timing for clock source and power gating
package csp_pkg;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_FAST_TRIM   = 8'h00;
	localparam logic [7:0] OFS_SLOW_TRIM   = 8'h04;
	localparam logic [7:0] OFS_TEMP_TRIM_A = 8'h08;
	localparam logic [7:0] OFS_TEMP_TRIM_B = 8'h0C;
	localparam logic [7:0] OFS_PRESCALE    = 8'h10;
	localparam logic [7:0] OFS_POWER_RED   = 8'h14;
	localparam logic [7:0] OFS_STATUS      = 8'h18;
	localparam logic [7:0] OFS_CONFIG      = 8'h1C;

	// ****************************************
	// power reduction bit positions
	// ****************************************
	localparam int PR_CONVERTER = 0;
	localparam int PR_XCVR      = 1;
	localparam int PR_SERIAL    = 2;
	localparam int PR_TIMER_B   = 3;
	localparam int PR_TIMER_A   = 4;
	localparam int PR_WIDTH     = 5;

	// ****************************************
	// reset values and encodings
	// ****************************************
	localparam logic [7:0] TEMP_TRIM_RESET  = 8'h00;
	localparam logic [3:0] PRESCALE_DIV8    = 4'h3;
	localparam logic [3:0] PRESCALE_DIV1    = 4'h0;
	localparam logic [3:0] PRESCALE_MAX     = 4'h8;
	localparam logic [1:0] SRC_FAST_RC      = 2'h2;
	localparam logic [1:0] SRC_SLOW_RC      = 2'h3;
	localparam logic [4:0] PR_RESET         = 5'h00;

	// ****************************************
	// start-up delays
	// ****************************************
	localparam int CLK_MHZ       = 40;
	localparam int STARTUP_US_S  = 16;
	localparam int STARTUP_US_L  = 64;
	localparam int STARTUP_CYC_S = STARTUP_US_S * CLK_MHZ;
	localparam int STARTUP_CYC_L = STARTUP_US_L * CLK_MHZ;
	localparam int CNT_W         = 12;

	// ****************************************
	// ahb constants
	// ****************************************
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	// non-volatile configuration straps
	typedef struct packed {
		logic [1:0] clock_source_select;
		logic       startup_time_select;
		logic       default_divide_by_eight;
	} csp_nvcfg_t;

	// gated module clock enables
	typedef struct packed {
		logic timer_a;
		logic timer_b;
		logic serial_periph;
		logic serial_xcvr;
		logic converter;
		logic comparator;
	} csp_gate_t;

	typedef enum logic [1:0] {ST_RESET, ST_STARTUP, ST_RUN} csp_state_t;

endpackage : csp_pkg

// File: rtl/csp_prescaler.sv
// file: system clock prescaler producing a glitch-free enable pulse
`timescale 1ns/10ps

module csp_prescaler import csp_pkg::*; #(
	parameter int DIV_W = 8
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       run,
	input  wire logic [3:0] shift,
	// output
	output logic            tick
);

	logic [DIV_W-1:0] count;
	logic [DIV_W-1:0] next_count;
	logic [DIV_W-1:0] limit;
	logic             next_tick;

	assign limit = DIV_W'((1 << shift) - 1);

	// ****************************************
	// divider
	// ****************************************
	// ratio change takes effect at once
	// counter restarts once it reaches or passes the limit, so a lowered ratio can give one short interval
	always_comb begin
		next_count = count;
		next_tick  = 1'b0;
		if (run) begin
			if (count >= limit) begin
				next_count = '0;
				next_tick  = 1'b1;
			end else begin
				next_count = count + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end

endmodule // csp_prescaler

// File: verification/csp_clock_ctrl_assertions.sv
// checker: port assertions for the clock control block
`timescale 1ns/10ps

module csp_clock_ctrl_assertions import csp_pkg::*; #(
	parameter int               STARTUP_SHORT = STARTUP_CYC_S,
	parameter int               STARTUP_LONG  = STARTUP_CYC_L,
	parameter logic [CNT_W-1:0] WDOG_DIV      = 12'hFFF
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// straps and bus
	input wire logic [7:0]  factory_fast_trim,
	input wire logic [7:0]  factory_slow_trim,
	input wire csp_nvcfg_t  nvcfg,
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	// watched outputs
	input wire logic [7:0]  fast_osc_trim,
	input wire logic [7:0]  slow_osc_trim,
	input wire logic [7:0]  fast_osc_temp_trim_a,
	input wire logic        sys_clk_en,
	input wire logic        wdog_clk_en,
	input wire logic        core_reset_n,
	input wire csp_gate_t   gate_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	logic [8:0]       wr_ph;
	logic [7:0]       wr_low;
	logic [CNT_W-1:0] wd_cnt;
	logic             wd_seen;
	int               up_cnt;
	int               su_len;

	assign su_len = nvcfg.startup_time_select ? STARTUP_LONG : STARTUP_SHORT;

	// write address held over its data phase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ph   <= 9'h000;
			wr_low  <= 8'h00;
			wd_cnt  <= 12'h000;
			wd_seen <= 1'b0;
			up_cnt  <= 0;
		end else begin
			if (hready)
				wr_ph <= {hsel & htrans[1] & hwrite, haddr};
			wr_low  <= hwdata[7:0];
			wd_cnt  <= wdog_clk_en ? 12'h000 : wd_cnt + 12'h001;
			wd_seen <= wd_seen | wdog_clk_en;
			up_cnt  <= up_cnt + 1;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_fast_load;
		$rose(core_reset_n) |-> fast_osc_trim == factory_fast_trim;
	endproperty
	a_fast_load: assert property (p_fast_load) else $error("fast trim not loaded");
	property p_slow_load;
		$rose(core_reset_n) |-> slow_osc_trim == factory_slow_trim;
	endproperty
	a_slow_load: assert property (p_slow_load) else $error("slow trim not loaded");
	property p_fast_wr;
		wr_ph == {1'b1, OFS_FAST_TRIM} && core_reset_n |=> fast_osc_trim == wr_low;
	endproperty
	a_fast_wr: assert property (p_fast_wr) else $error("fast trim write lost");
	property p_temp_wr;
		wr_ph == {1'b1, OFS_TEMP_TRIM_A} && core_reset_n |=> fast_osc_temp_trim_a == wr_low;
	endproperty
	a_temp_wr: assert property (p_temp_wr) else $error("temp trim write lost");
	// the watchdog tick ignores prescaler and gating
	property p_wdog;
		wd_seen |-> (wdog_clk_en ? wd_cnt == WDOG_DIV : wd_cnt < WDOG_DIV);
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog tick spacing");
	property p_startup;
		$rose(core_reset_n) |-> up_cnt inside {[su_len + 1 : su_len + 6]};
	endproperty
	a_startup: assert property (p_startup) else $error("start-up delay length");
	property p_gate_tick;
		|gate_en |-> sys_clk_en;
	endproperty
	a_gate_tick: assert property (p_gate_tick) else $error("gate pulse off tick");
	property p_comp;
		gate_en.comparator == gate_en.converter;
	endproperty
	a_comp: assert property (p_comp) else $error("comparator gate split");

	c_run: cover property ($rose(core_reset_n));
	c_write: cover property (wr_ph[8]);
	c_timer: cover property (gate_en.timer_b);

endmodule // csp_clock_ctrl_assertions

bind csp_clock_ctrl csp_clock_ctrl_assertions #(.STARTUP_SHORT(STARTUP_SHORT),
	.STARTUP_LONG(STARTUP_LONG), .WDOG_DIV(WDOG_DIV)) csp_chk_inst (.clk, .reset_n,
	.factory_fast_trim, .factory_slow_trim, .nvcfg, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .fast_osc_trim, .slow_osc_trim, .fast_osc_temp_trim_a,
	.sys_clk_en, .wdog_clk_en, .core_reset_n, .gate_en);

// File: verification/tb.sv
// testbench: boot, trims, prescaler and power gating over the bus
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_total++; $display("unexpected %s exp %h got %h", n, e, a); end end

module tb import csp_pkg::*;;
	logic        clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
	logic        fast_osc_en, slow_osc_en, sys_clk_en, wdog_clk_en, core_reset_n;
	logic [1:0]  htrans;
	logic [7:0]  haddr, fast_osc_trim, slow_osc_trim, temp_a, temp_b;
	logic [7:0]  factory_fast, factory_slow;
	logic [31:0] hwdata, hrdata, q;
	csp_nvcfg_t  nvcfg;
	csp_gate_t   gate_en;
	int          err_total, samples_checked, n;
	integer      pc[6];

	assign hready = hreadyout;
	always #12.5 clk = ~clk;

	// short start-up and watchdog counts keep the run brief
	csp_clock_ctrl #(.STARTUP_SHORT(4), .STARTUP_LONG(8), .WDOG_DIV(12'h003)) csp_clock_ctrl_inst (
		.clk, .reset_n, .factory_fast_trim(factory_fast), .factory_slow_trim(factory_slow), .nvcfg,
		.hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
		.hreadyout, .hresp, .fast_osc_trim, .slow_osc_trim, .fast_osc_temp_trim_a(temp_a),
		.fast_osc_temp_trim_b(temp_b), .fast_osc_en, .slow_osc_en, .sys_clk_en,
		.wdog_clk_en, .core_reset_n, .gate_en);

	// ****************************************
	// bus and measurement tasks
	// ****************************************
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= wr;
		htrans <= HTRANS_NONSEQ;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
		xfer(1'b0, a, 32'h0);
		`CHK(s, e, q)
		`CHK("hresp", 1'b0, hresp)
	endtask

	task automatic boot(input csp_nvcfg_t c);
		reset_n <= 1'b0;
		nvcfg   <= c;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		n = 0;
		while (core_reset_n !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
	endtask

	// first pulse after a ratio change may be partial, so skip two
	task automatic gap(input int e, input string s);
		repeat (2) do @(posedge clk); while (sys_clk_en !== 1'b1);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (sys_clk_en !== 1'b1 && n < 600);
		`CHK(s, e, n)
	endtask

	task automatic win();
		pc = '{default:0};
		repeat (2) @(posedge clk);
		repeat (20) begin
			@(posedge clk);
			for (int g = 0; g < 6; g++)
				pc[g] += gate_en[g];
		end
	endtask

	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 8'h00;
		hwdata = 32'h0;
		nvcfg = {SRC_FAST_RC, 2'b11};
		factory_fast = 8'hA5;
		factory_slow = 8'h3C;
		err_total = 0;
		samples_checked = 0;
		@(posedge clk);
		for (int k = 0; k < 2; k++) begin
			factory_fast <= k ? 8'h96 : 8'hA5;
			factory_slow <= k ? 8'h69 : 8'h3C;
			boot(k ? {SRC_SLOW_RC, 2'b00} : {SRC_FAST_RC, 2'b11});
			`CHK("running", 1'b1, core_reset_n)
			rd(OFS_FAST_TRIM, k ? 32'h96 : 32'hA5, "fast trim");
			rd(OFS_SLOW_TRIM, k ? 32'h69 : 32'h3C, "slow trim");
			`CHK("slow trim pin", k ? 8'h69 : 8'h3C, slow_osc_trim)
			rd(OFS_STATUS, {28'h0, 2'b11, k ? SRC_SLOW_RC : SRC_FAST_RC}, "status");
			rd(OFS_CONFIG, {28'h0, nvcfg}, "config");
			rd(OFS_TEMP_TRIM_B, 32'h0, "temp trim b");
			rd(OFS_POWER_RED, 32'h0, "power reset");
			rd(OFS_PRESCALE, {28'h0, k ? PRESCALE_DIV1 : PRESCALE_DIV8}, "prescale");
			`CHK("slow osc", k[0], slow_osc_en)
			`CHK("fast osc", 1'b1, fast_osc_en)
			gap(k ? 1 : 8, "tick gap");
			$display("test boot %0d done", k);
		end
		xfer(1'b1, OFS_FAST_TRIM, 32'hFFFF_FF5A);
		rd(OFS_FAST_TRIM, 32'h5A, "fast trim wr");
		`CHK("fast trim pin", 8'h5A, fast_osc_trim)
		xfer(1'b1, OFS_TEMP_TRIM_A, 32'h11);
		xfer(1'b1, OFS_TEMP_TRIM_B, 32'h22);
		rd(OFS_TEMP_TRIM_A, 32'h11, "temp trim a");
		rd(OFS_TEMP_TRIM_B, 32'h22, "temp trim b");
		`CHK("temp trim a pin", 8'h11, temp_a)
		`CHK("temp trim b pin", 8'h22, temp_b)
		rd(8'h20, 32'h0, "unmapped");
		$display("test trims done");
		xfer(1'b1, OFS_PRESCALE, {28'h0, PRESCALE_MAX});
		gap(256, "gap after step");
		xfer(1'b1, OFS_PRESCALE, 32'h9);
		rd(OFS_PRESCALE, {28'h0, PRESCALE_MAX}, "prescale refuse");
		xfer(1'b1, OFS_PRESCALE, 32'h0);
		$display("test prescaler done");
		for (int b = 0; b <= PR_WIDTH; b++) begin
			xfer(1'b1, OFS_POWER_RED, b < PR_WIDTH ? 32'h1 << b : 32'h0);
			win();
			for (int g = 0; g < 6; g++)
				`CHK("gate pulses", (g == b + 1 || (b == 0 && g == 0)) ? 0 : 20, pc[g])
		end
		$display("test gating done");
		test_done();
	end

	initial begin
		#500000;
		err_total++;
		test_done();
	end

endmodule // tb
